/* File: common/global_bank_regs.svh */
`ifndef GLOBAL_BANK_REGS_SVH
`define GLOBAL_BANK_REGS_SVH
// ************************************************************
// Address map
// ************************************************************
`define ADDR_W            13
`define PORT_STRIDE       13'h0200
`define PORT2_OFFSET      13'h0200
`define PORT3_OFFSET      13'h0400
`define PORT4_OFFSET      13'h0600
`define FRAMER_BASE       13'h0000
`define LIU_BASE          13'h0800
`define CELLPKT_BASE      13'h1000
`define PORT_WIN_SPAN     13'h0800
`define GLOBAL_LO         13'h1800
`define GLOBAL_HI         13'h181f
`define GLOBAL_ZERO_LO    13'h1812
`define RX_SYS_LO         13'h1900
`define RX_SYS_HI         13'h190f
`define TX_SYS_LO         13'h1940
`define TX_SYS_HI         13'h194f
// ************************************************************
// Global register offsets
// ************************************************************
`define OFF_IDENTITY      13'h1800
`define OFF_CTRL_ONE      13'h1801
`define OFF_CTRL_TWO      13'h1802
`define OFF_CTRL_THREE    13'h1803
`define OFF_CTRL_FOUR     13'h1804
`define OFF_CTRL_FIVE     13'h1805
`define OFF_CLOCK_CTRL    13'h1806
`define OFF_SOFT_RESET    13'h1807
`define OFF_MARKER_SEL    13'h1808
`define OFF_STATUS_ONE    13'h1809
`define OFF_STATUS_TWO    13'h180a
`define OFF_STATUS_THREE  13'h180b
`define OFF_STATUS_FOUR   13'h180c
`define OFF_STATUS_LATCH4 13'h180d
`define OFF_MASK_ONE      13'h180e
`define OFF_MASK_TWO      13'h180f
`define OFF_MASK_THREE    13'h1810
`define OFF_MASK_FOUR     13'h1811
// ************************************************************
// Fields and reset values
// ************************************************************
`define CTRL_RESET        8'h00
`define BIT_CHIP_RST      0
`define BIT_DP_RST        1
`define BIT_CP_RST        2
`define BIT_DIRECT        3
`define PROTO_LSB         4
`define WIDTH_LSB         6
`define BIT_ERR_INS       0
`define BIT_MON_UPD       1
`define BIT_BERT_UPD      2
`define BUS_W8            2'b00
`define BUS_W16           2'b01
`define MIN_RESET_NS      100
`define MCLK_PERIOD_NS    50
`endif

/* File: common/global_bank_pkg.sv */
package global_bank_pkg;
   typedef enum logic [1:0]
   {
      width_8_type_v   = 2'b00,
      width_16_type_v  = 2'b01,
      width_rsv2_v     = 2'b10,
      width_rsv3_v     = 2'b11
   } bus_width_type;

   typedef enum logic [1:0]
   {
      proto_cell_l2_v  = 2'b00,
      proto_cell_l3_v  = 2'b01,
      proto_pkt_l2_v   = 2'b10,
      proto_pkt_l3_v   = 2'b11
   } protocol_type;

   typedef enum logic [3:0]
   {
      win_none_v      = 4'h0,
      win_framer_v    = 4'h1,
      win_liu_v       = 4'h2,
      win_cellpkt_v   = 4'h3,
      win_global_v    = 4'h4,
      win_rx_sys_v    = 4'h5,
      win_tx_sys_v    = 4'h6
   } window_type;

   typedef struct packed
   {
      window_type  window;
      logic [1:0]  port;
      logic [8:0]  local_addr;
   } decode_type;

   typedef struct packed
   {
      bus_width_type system_bus_width;
      protocol_type  system_protocol_select;
      logic          direct_status_select;
      logic          cellpkt_full_reset;
      logic          cellpkt_datapath_reset;
      logic          chip_wide_reset;
   } global_cfg_type;
endpackage

/* File: rtl/rise_pulse.sv */
`timescale 1ns/1ps
// ************************************************************
// Rising edge to one-cycle pulse
// ************************************************************
module rise_pulse
(
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic level,
   output logic      pulse
);
   logic level_q;

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         level_q <= 1'b0;
      end
      else
      begin
         level_q <= level;
      end
   end

   assign pulse = level & ~level_q;
endmodule

/* File: rtl/global_control_register_bank.sv */
`timescale 1ns/1ps
// Contract
// (RULE1) Ports two-four windows offset 0200/0400/0600
// (RULE2) Global registers decoded at 1800-181F
// (RULE3) Receive system registers at 1900-190F
// (RULE4) Transmit system registers at 1940-194F
// (RULE5) Host writes zero to 1812-18FF
// (RULE6) Identity nibble in bits seven-four
// (RULE7) Die revision nibble in bits three-zero
// (RULE8) Width 00 eight bit, 01 sixteen
// (RULE9) Mode selects cell/packet level protocol
// (RULE10) Bit three selects polled or direct
// (RULE11) Cell/packet reset clears all its registers
// (RULE12) Datapath reset clears datapath registers only
// (RULE13) Chip reset clears all unit registers
// (RULE14) Host holds reset bits 100ns minimum
// (RULE15) Both control bytes reset to zero
// (RULE16) Monitor update rise captures, clears counters
// (RULE17) Error insert rise strobes enabled ports
// (RULE18) Global reads return contents; identity read-only
`include "global_bank_regs.svh"
module global_control_register_bank
   import global_bank_pkg::*;
#(
   parameter logic [3:0] DEVICE_IDENTITY = 4'h5,  // Arbitrary value
   parameter logic [3:0] DIE_REVISION    = 4'h1,
   parameter int         NUM_PORTS       = 4
)
(
   input  wire logic                 mclk,
   input  wire logic                 srst,
   input  wire logic [`ADDR_W-1:0]   addr,
   input  wire logic                 wr_en,
   input  wire logic                 rd_en,
   input  wire logic [7:0]           wr_data,
   output logic      [7:0]           rd_data,
   output logic                      rd_valid,
   input  wire logic [7:0]           status_one,
   input  wire logic [7:0]           status_two,
   input  wire logic [7:0]           status_three,
   input  wire logic [7:0]           status_four,
   input  wire logic [7:0]           status_latch_four,
   output decode_type                decode,
   output logic      [NUM_PORTS-1:0] port_select,
   output logic                      unit_wr_en,
   output logic                      unit_rd_en,
   output global_cfg_type            cfg,
   output logic                      framer_unit_reset,
   output logic                      liu_unit_reset,
   output logic                      cellpkt_config_reset,
   output logic                      cellpkt_datapath_clear,
   output logic                      monitor_update_strobe,
   output logic                      bit_tester_update_strobe,
   output logic                      manual_error_insert,
   output logic      [7:0]           ctrl_three,
   output logic      [7:0]           ctrl_four,
   output logic      [7:0]           ctrl_five,
   output logic      [7:0]           clock_ctrl,
   output logic      [7:0]           soft_reset_ctrl,
   output logic      [7:0]           marker_sel,
   output logic      [7:0]           mask_one,
   output logic      [7:0]           mask_two,
   output logic      [7:0]           mask_three,
   output logic      [7:0]           mask_four
);
   localparam int MIN_RESET_CYCLES = (`MIN_RESET_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;

   // Decode serves exactly four ports
   if (NUM_PORTS != 4)
   begin : g_port_count_check
      $error("NUM_PORTS must be 4");
   end

   if (MIN_RESET_CYCLES < 1)
   begin : g_reset_hold_check
      $error("reset hold count below one");
   end

   logic [7:0] ctrl_one_q;
   logic [7:0] ctrl_two_q;
   logic [7:0] ctrl_three_q;
   logic [7:0] ctrl_four_q;
   logic [7:0] ctrl_five_q;
   logic [7:0] clock_ctrl_q;
   logic [7:0] soft_reset_q;
   logic [7:0] marker_sel_q;
   logic [7:0] mask_one_q;
   logic [7:0] mask_two_q;
   logic [7:0] mask_three_q;
   logic [7:0] mask_four_q;
   logic [7:0] rd_data_q;
   logic       rd_valid_q;
   decode_type dec_d;
   logic       in_global;
   logic [`ADDR_W-1:0] port_rel;

   // ************************************************************
   // Address decode
   // ************************************************************
   always_comb
   begin
      dec_d      = '{window: win_none_v, port: 2'b00, local_addr: 9'h000};
      port_rel   = addr;
      in_global  = 1'b0;
      if (addr < `PORT_WIN_SPAN)
      begin
         dec_d.window = win_framer_v;
         port_rel     = addr - `FRAMER_BASE;
      end
      else if (addr < `CELLPKT_BASE)
      begin
         dec_d.window = win_liu_v;
         port_rel     = addr - `LIU_BASE;
      end
      else if (addr < `GLOBAL_LO)
      begin
         dec_d.window = win_cellpkt_v;
         port_rel     = addr - `CELLPKT_BASE;
      end
      // Port index from 0200-wide stride; port one has no displacement
      if (dec_d.window != win_none_v)
      begin
         dec_d.port       = port_rel[10:9];                          // [RULE1]
         dec_d.local_addr = port_rel[8:0];                           // [RULE1]
      end
      if (addr >= `GLOBAL_LO && addr <= `GLOBAL_HI)
      begin
         dec_d.window     = win_global_v;                            // [RULE2]
         dec_d.local_addr = {4'h0, addr[4:0]};
         in_global        = 1'b1;
      end
      else if (addr >= `RX_SYS_LO && addr <= `RX_SYS_HI)
      begin
         dec_d.window     = win_rx_sys_v;                            // [RULE3]
         dec_d.local_addr = {5'h00, addr[3:0]};
      end
      else if (addr >= `TX_SYS_LO && addr <= `TX_SYS_HI)
      begin
         dec_d.window     = win_tx_sys_v;                            // [RULE4]
         dec_d.local_addr = {5'h00, addr[3:0]};
      end
   end

   assign decode     = dec_d;
   assign unit_wr_en = wr_en & (dec_d.window != win_none_v) & ~in_global;
   assign unit_rd_en = rd_en & (dec_d.window != win_none_v) & ~in_global;

   always_comb
   begin
      port_select = '0;
      if (dec_d.window == win_framer_v || dec_d.window == win_liu_v || dec_d.window == win_cellpkt_v)
         port_select[dec_d.port] = 1'b1;                             // [RULE1]
   end

   // ************************************************************
   // Global control bytes
   // ************************************************************
   // Writes to 1812-18FF are dropped; host keeps them zero [RULE5]
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         ctrl_one_q <= `CTRL_RESET;                                  // [RULE15]
         ctrl_two_q <= `CTRL_RESET;                                  // [RULE15]
      end
      else if (wr_en && in_global)
      begin
         if (addr == `OFF_CTRL_ONE)
            ctrl_one_q <= wr_data;
         if (addr == `OFF_CTRL_TWO)
            ctrl_two_q <= wr_data;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         ctrl_three_q <= `CTRL_RESET;
         ctrl_four_q  <= `CTRL_RESET;
         ctrl_five_q  <= `CTRL_RESET;
         clock_ctrl_q <= `CTRL_RESET;
         soft_reset_q <= `CTRL_RESET;
         marker_sel_q <= `CTRL_RESET;
         mask_one_q   <= `CTRL_RESET;
         mask_two_q   <= `CTRL_RESET;
         mask_three_q <= `CTRL_RESET;
         mask_four_q  <= `CTRL_RESET;
      end
      else if (wr_en && in_global)
      begin
         // Identity byte has no storage, so its writes vanish [RULE18]
         case (addr)
            `OFF_CTRL_THREE : ctrl_three_q <= wr_data;
            `OFF_CTRL_FOUR  : ctrl_four_q  <= wr_data;
            `OFF_CTRL_FIVE  : ctrl_five_q  <= wr_data;
            `OFF_CLOCK_CTRL : clock_ctrl_q <= wr_data;
            `OFF_SOFT_RESET : soft_reset_q <= wr_data;
            `OFF_MARKER_SEL : marker_sel_q <= wr_data;
            `OFF_MASK_ONE   : mask_one_q   <= wr_data;
            `OFF_MASK_TWO   : mask_two_q   <= wr_data;
            `OFF_MASK_THREE : mask_three_q <= wr_data;
            `OFF_MASK_FOUR  : mask_four_q  <= wr_data;
            default         : ;
         endcase
      end
   end

   // ************************************************************
   // Configuration and reset fan-out
   // ************************************************************
   assign cfg.system_bus_width       = bus_width_type'(ctrl_one_q[`WIDTH_LSB+1:`WIDTH_LSB]); // [RULE8]
   assign cfg.system_protocol_select = protocol_type'(ctrl_one_q[`PROTO_LSB+1:`PROTO_LSB]); // [RULE9]
   assign cfg.direct_status_select   = ctrl_one_q[`BIT_DIRECT];                           // [RULE10]
   assign cfg.cellpkt_full_reset     = ctrl_one_q[`BIT_CP_RST];
   assign cfg.cellpkt_datapath_reset = ctrl_one_q[`BIT_DP_RST];
   assign cfg.chip_wide_reset        = ctrl_one_q[`BIT_CHIP_RST];

   // Level resets follow the bits; host holds them long enough [RULE14]
   assign framer_unit_reset      = ctrl_one_q[`BIT_CHIP_RST];                              // [RULE13]
   assign liu_unit_reset         = ctrl_one_q[`BIT_CHIP_RST];                              // [RULE13]
   assign cellpkt_config_reset   = ctrl_one_q[`BIT_CP_RST] | ctrl_one_q[`BIT_CHIP_RST];    // [RULE11] [RULE13]
   assign cellpkt_datapath_clear = ctrl_one_q[`BIT_DP_RST] | cellpkt_config_reset;         // [RULE12]

   // ************************************************************
   // Strobes from control byte two
   // ************************************************************
   rise_pulse mon_edge
   (
      .mclk  (mclk),
      .srst  (srst),
      .level (ctrl_two_q[`BIT_MON_UPD]),
      .pulse (monitor_update_strobe)                                 // [RULE16]
   );

   rise_pulse bert_edge
   (
      .mclk  (mclk),
      .srst  (srst),
      .level (ctrl_two_q[`BIT_BERT_UPD]),
      .pulse (bit_tester_update_strobe)
   );

   rise_pulse err_edge
   (
      .mclk  (mclk),
      .srst  (srst),
      .level (ctrl_two_q[`BIT_ERR_INS]),
      .pulse (manual_error_insert)                                   // [RULE17]
   );

   // ************************************************************
   // Read path
   // ************************************************************
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         rd_data_q  <= 8'h00;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         rd_valid_q <= rd_en & in_global;
         if (rd_en && in_global)
         begin
            case (addr)                                              // [RULE18]
               `OFF_IDENTITY      : rd_data_q <= {DEVICE_IDENTITY, DIE_REVISION};  // [RULE6] [RULE7]
               `OFF_CTRL_ONE      : rd_data_q <= ctrl_one_q;
               `OFF_CTRL_TWO      : rd_data_q <= ctrl_two_q;
               `OFF_CTRL_THREE    : rd_data_q <= ctrl_three_q;
               `OFF_CTRL_FOUR     : rd_data_q <= ctrl_four_q;
               `OFF_CTRL_FIVE     : rd_data_q <= ctrl_five_q;
               `OFF_CLOCK_CTRL    : rd_data_q <= clock_ctrl_q;
               `OFF_SOFT_RESET    : rd_data_q <= soft_reset_q;
               `OFF_MARKER_SEL    : rd_data_q <= marker_sel_q;
               `OFF_STATUS_ONE    : rd_data_q <= status_one;
               `OFF_STATUS_TWO    : rd_data_q <= status_two;
               `OFF_STATUS_THREE  : rd_data_q <= status_three;
               `OFF_STATUS_FOUR   : rd_data_q <= status_four;
               `OFF_STATUS_LATCH4 : rd_data_q <= status_latch_four;
               `OFF_MASK_ONE      : rd_data_q <= mask_one_q;
               `OFF_MASK_TWO      : rd_data_q <= mask_two_q;
               `OFF_MASK_THREE    : rd_data_q <= mask_three_q;
               `OFF_MASK_FOUR     : rd_data_q <= mask_four_q;
               default            : rd_data_q <= 8'h00;
            endcase
         end
      end
   end

   assign rd_data         = rd_data_q;
   assign rd_valid        = rd_valid_q;
   assign ctrl_three      = ctrl_three_q;
   assign ctrl_four       = ctrl_four_q;
   assign ctrl_five       = ctrl_five_q;
   assign clock_ctrl      = clock_ctrl_q;
   assign soft_reset_ctrl = soft_reset_q;
   assign marker_sel      = marker_sel_q;
   assign mask_one        = mask_one_q;
   assign mask_two        = mask_two_q;
   assign mask_three      = mask_three_q;
   assign mask_four       = mask_four_q;
endmodule

/* File: tb/global_bank_chk.sv */
`timescale 1ns/1ps
`include "global_bank_regs.svh"
// ********************
// Port checker
// ********************
module global_bank_chk
   import global_bank_pkg::*;
#(
   parameter logic [3:0] DEVICE_IDENTITY = 4'h5,
   parameter logic [3:0] DIE_REVISION    = 4'h1,
   parameter int         NUM_PORTS       = 4
)
(
   input wire logic                 mclk,
   input wire logic                 srst,
   input wire logic [`ADDR_W-1:0]   addr,
   input wire logic                 wr_en,
   input wire logic                 rd_en,
   input wire logic [7:0]           wr_data,
   input wire logic [7:0]           rd_data,
   input wire logic                 rd_valid,
   input wire decode_type           decode,
   input wire logic [NUM_PORTS-1:0] port_select,
   input wire global_cfg_type       cfg,
   input wire logic                 framer_unit_reset,
   input wire logic                 liu_unit_reset,
   input wire logic                 cellpkt_config_reset,
   input wire logic                 cellpkt_datapath_clear,
   input wire logic                 monitor_update_strobe,
   input wire logic                 manual_error_insert
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   logic glob;
   assign glob = (addr >= `GLOBAL_LO) && (addr <= `GLOBAL_HI);

   chk_read_answer: assert property (rd_en && glob |=> rd_valid)
      else $error("global read gave no answer");
   chk_no_stray: assert property (!(rd_en && glob) |=> !rd_valid)
      else $error("answer without a global read");
   chk_ident_value: assert property (rd_en && addr == `OFF_IDENTITY |=> rd_data == {DEVICE_IDENTITY, DIE_REVISION})
      else $error("identity byte wrong");
   chk_cfg_write: assert property (wr_en && addr == `OFF_CTRL_ONE |=> cfg == $past(wr_data))
      else $error("control byte one not taken");
   chk_cfg_reset: assert property ($fell(srst) |-> cfg == 8'h00)
      else $error("control byte one not zero after reset");
   chk_mon_cause: assert property (monitor_update_strobe |-> $past(wr_en && addr == `OFF_CTRL_TWO && wr_data[1]))
      else $error("monitor update without its write");
   chk_mon_single: assert property ($rose(monitor_update_strobe) |=> !monitor_update_strobe)
      else $error("monitor update longer than one cycle");
   chk_err_cause: assert property (manual_error_insert |-> $past(wr_en && addr == `OFF_CTRL_TWO && wr_data[0]))
      else $error("error insert without its write");
   chk_chip_reset: assert property (cfg.chip_wide_reset |-> framer_unit_reset && liu_unit_reset && cellpkt_config_reset && cellpkt_datapath_clear)
      else $error("chip reset not spread");
   chk_cp_reset: assert property (cellpkt_config_reset == (cfg.cellpkt_full_reset || cfg.chip_wide_reset))
      else $error("cell reset level wrong");
   chk_dp_clear: assert property (cfg == 8'h02 |-> cellpkt_datapath_clear && !cellpkt_config_reset && !framer_unit_reset)
      else $error("datapath clear wrong");
   chk_port_decode: assert property (addr < `GLOBAL_LO |-> port_select[addr[10:9]] && $onehot(port_select) && decode.port == addr[10:9])
      else $error("port decode wrong");
   chk_rx_window: assert property (addr >= `RX_SYS_LO && addr <= `RX_SYS_HI |-> decode.window == win_rx_sys_v)
      else $error("receive system window wrong");
   chk_tx_window: assert property (addr >= `TX_SYS_LO && addr <= `TX_SYS_HI |-> decode.window == win_tx_sys_v)
      else $error("transmit system window wrong");

   cover property (rd_en && addr == `OFF_IDENTITY ##1 rd_valid);
   cover property (monitor_update_strobe);
   cover property (manual_error_insert);
   cover property (cellpkt_datapath_clear && !cellpkt_config_reset);
endmodule

bind global_control_register_bank global_bank_chk #(.DEVICE_IDENTITY(DEVICE_IDENTITY), .DIE_REVISION(DIE_REVISION),
   .NUM_PORTS(NUM_PORTS)) global_bank_chk_i (.mclk, .srst, .addr, .wr_en, .rd_en, .wr_data, .rd_data, .rd_valid,
   .decode, .port_select, .cfg, .framer_unit_reset, .liu_unit_reset, .cellpkt_config_reset, .cellpkt_datapath_clear,
   .monitor_update_strobe, .manual_error_insert);

/* File: tb/host_model.sv */
`timescale 1ns/1ps
`include "global_bank_regs.svh"
// ********************
// Host bus master
// ********************
module host_model
(
   input  wire logic               mclk,
   output logic      [`ADDR_W-1:0] addr,
   output logic                    wr_en,
   output logic                    rd_en,
   output logic      [7:0]         wr_data
);
   initial
   begin
      addr    = `GLOBAL_LO;
      wr_en   = 1'b0;
      rd_en   = 1'b0;
      wr_data = 8'h00;
   end
   task automatic write_byte(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr    <= a;
      wr_en   <= 1'b1;
      wr_data <= (a >= `GLOBAL_ZERO_LO && a <= 13'h18ff) ? 8'h00 : d;
      @(posedge mclk);
      wr_en   <= 1'b0;
      wr_data <= ~d;
   endtask
   task automatic read_req(input logic [`ADDR_W-1:0] a);
      @(posedge mclk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
   endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "global_bank_regs.svh"
module tb_top;
   import global_bank_pkg::*;
   localparam logic [3:0] DEV_ID  = 4'ha;  // Arbitrary value
   localparam logic [3:0] DEV_REV = 4'h3;
   logic                 mclk;
   logic                 srst;
   logic [`ADDR_W-1:0]   addr;
   logic                 wr_en;
   logic                 rd_en;
   logic [7:0]           wr_data;
   logic [7:0]           rd_data;
   logic                 rd_valid;
   logic [7:0]           st [0:4];
   logic [7:0]           regs [0:17];
   logic [7:0]           exp_q [$];
   logic [31:0]          seed;
   decode_type           decode;
   logic [3:0]           port_select;
   global_cfg_type       cfg;
   logic                 fr_rst;
   logic                 liu_rst;
   logic                 cp_rst;
   logic                 dp_clr;
   logic                 mon_s;
   logic                 bert_s;
   logic                 err_s;
   int                   err_count;
   int                   checked;
   int                   mon_n;
   int                   bert_n;
   int                   err_n;

   host_model host_model_i (.mclk(mclk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data));
   global_control_register_bank #(.DEVICE_IDENTITY(DEV_ID), .DIE_REVISION(DEV_REV)) global_control_register_bank_i
   (
      .mclk(mclk), .srst(srst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
      .rd_valid(rd_valid), .status_one(st[0]), .status_two(st[1]), .status_three(st[2]), .status_four(st[3]),
      .status_latch_four(st[4]), .decode(decode), .port_select(port_select), .unit_wr_en(), .unit_rd_en(),
      .cfg(cfg), .framer_unit_reset(fr_rst), .liu_unit_reset(liu_rst), .cellpkt_config_reset(cp_rst),
      .cellpkt_datapath_clear(dp_clr), .monitor_update_strobe(mon_s), .bit_tester_update_strobe(bert_s),
      .manual_error_insert(err_s), .ctrl_three(), .ctrl_four(), .ctrl_five(), .clock_ctrl(), .soft_reset_ctrl(),
      .marker_sel(), .mask_one(), .mask_two(), .mask_three(), .mask_four()
   );

   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      checked++;
      if (seen !== expv)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [`ADDR_W-1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host_model_i.read_req(a);
   endtask
   task automatic read_all();
      for (int i = 0; i < 32; i++)
         rd(`GLOBAL_LO + 13'(i), (i < 18) ? regs[i] : 8'h00);
   endtask

   // ********************
   // Clock, watchdog, result monitor
   // ********************
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      err_count++;
      give_verdict();
   end
   always @(negedge mclk)
   begin
      mon_n  += int'(mon_s === 1'b1);
      bert_n += int'(bert_s === 1'b1);
      err_n  += int'(err_s === 1'b1);
      if (rd_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(32'h1, 32'h0);
         else
            check(rd_data, exp_q.pop_front());
      end
   end

   // ********************
   // Scenarios
   // ********************
   initial
   begin
      srst = 1'b1;
      seed = 32'h7a9d;
      regs[0] = {DEV_ID, DEV_REV};
      for (int i = 1; i < 18; i++)
         regs[i] = 8'h00;
      for (int i = 0; i < 5; i++)
      begin
         seed = lfsr_step(seed);
         st[i] = seed[7:0];
         regs[9 + i] = seed[7:0];
      end
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      read_all();
      for (int i = 0; i < 18; i++)
      begin
         seed = lfsr_step(seed);
         host_model_i.write_byte(`GLOBAL_LO + 13'(i), seed[7:0]);
         if (i != 0 && (i < 9 || i > 13))
            regs[i] = seed[7:0];
      end
      seed = lfsr_step(seed);
      host_model_i.write_byte(13'h1815, seed[7:0]);
      read_all();
      host_model_i.read_req(13'h1820);
      for (int m = 0; m < 16; m++)
      begin
         host_model_i.write_byte(`OFF_CTRL_ONE, {4'(m), m[0], 3'b000});
         @(negedge mclk);
         check(cfg.system_bus_width, m[3:2]);
         check(cfg.system_protocol_select, m[1:0]);
         check(cfg.direct_status_select, m[0]);
      end
      for (int b = 0; b < 3; b++)
      begin
         host_model_i.write_byte(`OFF_CTRL_ONE, 8'h01 << b);
         @(negedge mclk);
         check(fr_rst, b == 0);
         check(liu_rst, b == 0);
         check(cp_rst, b != 1);
         check(dp_clr, 1);
         repeat (3) @(posedge mclk);
         host_model_i.write_byte(`OFF_CTRL_ONE, 8'h00);
      end
      host_model_i.write_byte(`OFF_CTRL_TWO, 8'h00);
      @(negedge mclk);
      mon_n  = 0;
      bert_n = 0;
      err_n  = 0;
      host_model_i.write_byte(`OFF_CTRL_TWO, 8'h02);
      host_model_i.write_byte(`OFF_CTRL_TWO, 8'h02);
      host_model_i.write_byte(`OFF_CTRL_TWO, 8'h00);
      host_model_i.write_byte(`OFF_CTRL_TWO, 8'h07);
      repeat (2) @(negedge mclk);
      check(mon_n, 2);
      check(err_n, 1);
      check(bert_n, 1);
      for (int p = 0; p < 4; p++)
         for (int w = 0; w < 3; w++)
         begin
            seed = lfsr_step(seed);
            host_model_i.read_req(13'(w * 13'h0800 + p * `PORT_STRIDE) + {4'h0, seed[8:0]});
            @(negedge mclk);
            check(port_select, 4'h1 << p);
            check(decode.port, p);
            check(decode.window, w + 1);
            check(decode.local_addr, seed[8:0]);
         end
      host_model_i.read_req(13'h1905);
      @(negedge mclk);
      check(decode.window, win_rx_sys_v);
      check(decode.local_addr, 9'h005);
      host_model_i.read_req(13'h1945);
      @(negedge mclk);
      check(decode.window, win_tx_sys_v);
      check(decode.local_addr, 9'h005);
      repeat (2) @(negedge mclk);
      check(exp_q.size(), 0);
      give_verdict();
   end
endmodule
